// ### common/sspf_pkg.sv
// Shared constants and types for the synchronous serial port with FIFOs
package sspf_pkg;

	// ==================================================================
	// I/O register addresses
	localparam logic [15:0] SSPF_DATA_ADDR = 16'hfff0;
	localparam logic [15:0] SSPF_CTRL_ADDR = 16'hfff1;

	// ==================================================================
	// Sizes
	localparam int SSPF_WORD_W = 16;
	localparam int SSPF_FIFO_DEPTH = 4;
	localparam int SSPF_BUF_DEPTH = 2;

	// ==================================================================
	// Control register fields (bit positions)
	localparam int SSPF_CLK_INT_BIT = 0;
	localparam int SSPF_CONT_BIT = 1;
	localparam int SSPF_FS_INT_BIT = 2;
	localparam int SSPF_RX_RUN_BIT = 4;
	localparam int SSPF_TX_RUN_BIT = 5;
	localparam int SSPF_DIV_LSB = 8;
	localparam int SSPF_RX_FIFO_NOT_EMPTY_BIT = 12;
	localparam int SSPF_TX_COMPLETE_BIT = 13;
	localparam int SSPF_RFULL_BIT = 14;
	localparam int SSPF_TFULL_BIT = 15;
	localparam logic [15:0] SSPF_CFG_MASK = 16'h0f37;
	localparam logic [15:0] SSPF_CTRL_RST = 16'h0000;

	// ==================================================================
	// Types
	typedef struct packed {
		logic [3:0] status;
		logic [3:0] clk_div;
		logic [1:0] spare_hi;
		logic tx_run;
		logic rx_run;
		logic spare_lo;
		logic fs_int;
		logic cont;
		logic clk_int;
	} sspf_ctrl_t;

	typedef struct packed {
		logic cont;
		logic fs_int;
		logic tx_run;
		logic rx_run;
	} sspf_link_cfg_t;

	typedef enum {LT_IDLE, LT_SYNC, LT_SHIFT} sspf_tx_state_t;

endpackage

// ### src/sspf_port.sv
// Synchronous serial port with transmit and receive FIFOs
`timescale 1ns/100ps

// Function
// - Separate transmit and receive FIFOs, four words each.
// - Internal bit clock never faster than half the processor clock.
// - Burst or continuous transfers, chosen in the control register.
// - Bit clock made internally or taken from outside; source drives it.
// - Frame sync starts every transfer; internal or external source.
// - Data leaves on serial out, arrives on serial in, crossed wiring.
// - Data and control registers at I/O FFF0h, FFF1h; writes fill TX FIFO.
// - Oldest TX word moves to the hand-off register whenever that register is free.
// - Transmit shifter sends one bit per bit clock, MSB first.
// - Shifter empty loads next word, or stops and raises transmit interrupt.
// - Incoming bits shift into the receive shifter, MSB first.
// - Complete received word goes into the RX FIFO; reception resumes.
// - Receive interrupt only when the RX FIFO becomes full.
// - Reading the data register returns and removes the oldest RX word.
// - Control bit 13 reports transmit complete after the word leaves.
// - Control bit 12 reports received data waiting in the RX FIFO.
// - With shared bit clocks, receive interrupt beats transmit interrupt.
module sspf_port import sspf_pkg::*; #(
	parameter int WORD_W = SSPF_WORD_W,
	parameter int DEPTH = SSPF_FIFO_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_wdata_i,
	output logic [15:0] io_rdata_o,
	output logic io_rvalid_o,
	output logic transmit_interrupt_o,
	output logic receive_interrupt_o,
	input wire logic bit_clk_i,
	output logic bit_clk_o,
	output logic bit_clk_oe_o,
	input wire logic frame_sync_i,
	output logic frame_sync_o,
	output logic frame_sync_oe_o,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o
);

	// ==================================================================
	// Elaboration checks
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int BW = $clog2(WORD_W);
	generate
		if (WORD_W != 16 || DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
			$error("sspf_port: WORD_W must be 16, DEPTH a power of two");
		end
	endgenerate

	// ==================================================================
	// Register decode and control register
	sspf_ctrl_t ctrl;
	logic wr_data, wr_ctrl, rd_data, rd_ctrl;
	assign wr_data = io_wr_i && io_addr_i == SSPF_DATA_ADDR;
	assign wr_ctrl = io_wr_i && io_addr_i == SSPF_CTRL_ADDR;
	assign rd_data = io_rd_i && io_addr_i == SSPF_DATA_ADDR;
	assign rd_ctrl = io_rd_i && io_addr_i == SSPF_CTRL_ADDR;

	// Only the writable fields are kept; status bits are built on read
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl <= sspf_ctrl_t'(SSPF_CTRL_RST);
		end else if (wr_ctrl) begin
			ctrl <= sspf_ctrl_t'(io_wdata_i & SSPF_CFG_MASK);
		end
	end

	// ==================================================================
	// Internal bit clock divider
	// Half period is clk_div+1 system clocks, so the rate is at most half
	logic [3:0] div_cnt;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !ctrl.clk_int) begin
			div_cnt <= 4'h0;
			bit_clk_o <= 1'b0;
		end else if (div_cnt == ctrl.clk_div) begin
			div_cnt <= 4'h0;
			bit_clk_o <= ~bit_clk_o;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// Pin drivers follow the selected sources
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			bit_clk_oe_o <= 1'b0;
			frame_sync_oe_o <= 1'b0;
		end else begin
			bit_clk_oe_o <= ctrl.clk_int;
			frame_sync_oe_o <= ctrl.fs_int;
		end
	end

	// ==================================================================
	// Transmit FIFO (system domain)
	logic [WORD_W-1:0] tx_mem [DEPTH];
	logic [PW-1:0] tx_wp, tx_rp;
	logic [CW-1:0] tx_cnt;
	logic [WORD_W-1:0] tx_hold;
	logic hold_busy, tx_req, tx_push, tx_pop;
	logic ack_s1, ack_s2;
	assign tx_push = wr_data && tx_cnt != CW'(DEPTH);
	assign tx_pop = !hold_busy && tx_cnt != '0;

	always_ff @(posedge sys_clk_i) begin
		if (tx_push) begin
			tx_mem[tx_wp] <= io_wdata_i;
		end
	end

	// Pointers and fill level; a write to a full FIFO is dropped
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !ctrl.tx_run) begin
			tx_wp <= '0;
			tx_rp <= '0;
			tx_cnt <= '0;
		end else begin
			tx_wp <= tx_wp + PW'(tx_push);
			tx_rp <= tx_rp + PW'(tx_pop);
			tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
		end
	end

	// Hand-off word; held steady until the link side acknowledges it
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !ctrl.tx_run) begin
			tx_hold <= '0;
			hold_busy <= 1'b0;
			tx_req <= 1'b0;
		end else if (tx_pop) begin
			tx_hold <= tx_mem[tx_rp];
			hold_busy <= 1'b1;
			tx_req <= ~tx_req;
		end else if (hold_busy && ack_s2 == tx_req) begin
			hold_busy <= 1'b0;
		end
	end

	// ==================================================================
	// Link domain: synchronisers for reset, configuration and request
	sspf_link_cfg_t cfg_sys, cfg_l1, cfg_l2;
	logic rst_l1, rst_l2, req_l1, req_l2, ack_l;
	logic fs_d1, fs_d2, din_d1, din_d2;
	assign cfg_sys = '{cont: ctrl.cont, fs_int: ctrl.fs_int,
		tx_run: ctrl.tx_run, rx_run: ctrl.rx_run};

	always_ff @(posedge bit_clk_i) begin
		rst_l1 <= srst_i;
		rst_l2 <= rst_l1;
		cfg_l1 <= cfg_sys;
		cfg_l2 <= cfg_l1;
		req_l1 <= tx_req;
		req_l2 <= req_l1;
	end

	// Pin inputs pass two flops; data and sync stay aligned
	always_ff @(posedge bit_clk_i) begin
		fs_d1 <= frame_sync_i;
		fs_d2 <= fs_d1;
		din_d1 <= serial_data_in_i;
		din_d2 <= din_d1;
	end

	// ==================================================================
	// Link domain: transmit shifter
	sspf_tx_state_t lt_state;
	logic [WORD_W-1:0] tx_sr;
	logic [BW-1:0] tx_bit;
	logic tx_done, word_pend;
	assign word_pend = req_l2 != ack_l;

	// Burst mode sends a sync before every word; continuous mode only
	// before the first word of an unbroken run
	always_ff @(posedge bit_clk_i) begin
		if (rst_l2 || !cfg_l2.tx_run) begin
			lt_state <= LT_IDLE;
			tx_sr <= '0;
			tx_bit <= '0;
			ack_l <= req_l2;
			tx_done <= 1'b0;
			frame_sync_o <= 1'b0;
			serial_data_out_o <= 1'b0;
		end else begin
			frame_sync_o <= 1'b0;
			case (lt_state)
				LT_IDLE: begin
					serial_data_out_o <= 1'b0;
					if (word_pend) begin
						tx_sr <= tx_hold;
						ack_l <= ~ack_l;
						lt_state <= LT_SYNC;
						frame_sync_o <= cfg_l2.fs_int;
					end
				end
				LT_SYNC: begin
					// External sync: wait for the partner's pulse
					if (cfg_l2.fs_int || fs_d2) begin
						serial_data_out_o <= tx_sr[WORD_W-1];
						tx_sr <= {tx_sr[WORD_W-2:0], 1'b0};
						tx_bit <= BW'(WORD_W - 1);
						lt_state <= LT_SHIFT;
					end
				end
				LT_SHIFT: begin
					if (tx_bit != '0) begin
						serial_data_out_o <= tx_sr[WORD_W-1];
						tx_sr <= {tx_sr[WORD_W-2:0], 1'b0};
						tx_bit <= tx_bit - BW'(1);
					end else begin
						tx_done <= ~tx_done;
						if (word_pend && cfg_l2.cont) begin
							serial_data_out_o <= tx_hold[WORD_W-1];
							tx_sr <= {tx_hold[WORD_W-2:0], 1'b0};
							ack_l <= ~ack_l;
							tx_bit <= BW'(WORD_W - 1);
						end else if (word_pend) begin
							serial_data_out_o <= 1'b0;
							tx_sr <= tx_hold;
							ack_l <= ~ack_l;
							lt_state <= LT_SYNC;
							frame_sync_o <= cfg_l2.fs_int;
						end else begin
							serial_data_out_o <= 1'b0;
							lt_state <= LT_IDLE;
						end
					end
				end
				default: lt_state <= LT_IDLE;
			endcase
		end
	end

	// ==================================================================
	// Link domain: receive shifter
	logic [WORD_W-1:0] rx_sr, rx_word;
	logic [BW-1:0] rx_bit;
	logic rx_busy, rx_tgl, rx_start;
	// Internal sync is our own pulse, delayed to line up with the pins
	logic fs_own1, fs_own2;
	always_ff @(posedge bit_clk_i) begin
		fs_own1 <= frame_sync_o;
		fs_own2 <= fs_own1;
	end
	assign rx_start = cfg_l2.fs_int ? fs_own2 : fs_d2;

	always_ff @(posedge bit_clk_i) begin
		if (rst_l2 || !cfg_l2.rx_run) begin
			rx_busy <= 1'b0;
			rx_bit <= '0;
			rx_sr <= '0;
			rx_word <= '0;
			rx_tgl <= 1'b0;
		end else if (!rx_busy) begin
			if (rx_start) begin
				rx_busy <= 1'b1;
				rx_bit <= '0;
			end
		end else begin
			rx_sr <= {rx_sr[WORD_W-2:0], din_d2};
			rx_bit <= rx_bit + BW'(1);
			if (rx_bit == BW'(WORD_W - 1)) begin
				rx_word <= {rx_sr[WORD_W-2:0], din_d2};
				rx_tgl <= ~rx_tgl;
				rx_busy <= cfg_l2.cont;
			end
		end
	end

	// ==================================================================
	// Crossing back into the system domain
	// rx_word is stable for a whole word time after each toggle
	logic rt_s1, rt_s2, rt_s3, dn_s1, dn_s2, dn_s3;
	always_ff @(posedge sys_clk_i) begin
		ack_s1 <= ack_l;
		ack_s2 <= ack_s1;
		rt_s1 <= rx_tgl;
		rt_s2 <= rt_s1;
		rt_s3 <= rt_s2;
		dn_s1 <= tx_done;
		dn_s2 <= dn_s1;
		dn_s3 <= dn_s2;
	end

	// ==================================================================
	// Two-entry receive buffer ahead of the RX FIFO
	logic [WORD_W-1:0] bf_mem [SSPF_BUF_DEPTH];
	logic bf_wp, bf_rp;
	logic [1:0] bf_cnt;
	logic bf_valid, bf_ready, bf_in_valid, bf_in_ready, bf_push;
	logic [WORD_W-1:0] rx_mem [DEPTH];
	logic [PW-1:0] rx_wp, rx_rp;
	logic [CW-1:0] rx_cnt;
	logic rx_pop;
	assign bf_in_valid = rt_s2 != rt_s3;
	assign bf_in_ready = bf_cnt != 2'(SSPF_BUF_DEPTH);
	assign bf_push = bf_in_valid && bf_in_ready;
	assign bf_valid = bf_cnt != 2'd0;
	assign bf_ready = rx_cnt != CW'(DEPTH);
	assign rx_pop = rd_data && rx_cnt != '0;

	always_ff @(posedge sys_clk_i) begin
		if (bf_push) begin
			bf_mem[bf_wp] <= rx_word;
		end
	end

	// A full RX FIFO stalls the buffer; it drops only once both fill
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !ctrl.rx_run) begin
			bf_wp <= 1'b0;
			bf_rp <= 1'b0;
			bf_cnt <= 2'd0;
		end else begin
			bf_wp <= bf_wp ^ bf_push;
			bf_rp <= bf_rp ^ (bf_valid && bf_ready);
			bf_cnt <= bf_cnt + 2'(bf_push) - 2'(bf_valid && bf_ready);
		end
	end

	// ==================================================================
	// Receive FIFO
	always_ff @(posedge sys_clk_i) begin
		if (bf_valid && bf_ready) begin
			rx_mem[rx_wp] <= bf_mem[bf_rp];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !ctrl.rx_run) begin
			rx_wp <= '0;
			rx_rp <= '0;
			rx_cnt <= '0;
		end else begin
			rx_wp <= rx_wp + PW'(bf_valid && bf_ready);
			rx_rp <= rx_rp + PW'(rx_pop);
			rx_cnt <= rx_cnt + CW'(bf_valid && bf_ready) - CW'(rx_pop);
		end
	end

	// ==================================================================
	// Transmit-complete flag; a completion beats a same-cycle clear
	logic tx_comp, word_out;
	assign word_out = dn_s2 != dn_s3;
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !ctrl.tx_run) begin
			tx_comp <= 1'b0;
		end else if (word_out) begin
			tx_comp <= 1'b1;
		end else if (wr_data) begin
			tx_comp <= 1'b0;
		end
	end

	// ==================================================================
	// Register reads; the data read also pops the RX FIFO
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			io_rdata_o <= 16'h0000;
			io_rvalid_o <= 1'b0;
		end else begin
			io_rvalid_o <= rd_data || rd_ctrl;
			if (rd_data) begin
				io_rdata_o <= rx_cnt != '0 ? rx_mem[rx_rp] : 16'h0000;
			end else if (rd_ctrl) begin
				io_rdata_o <= 16'(ctrl);
				io_rdata_o[SSPF_RX_FIFO_NOT_EMPTY_BIT] <= rx_cnt != '0;
				io_rdata_o[SSPF_TX_COMPLETE_BIT] <= tx_comp;
				io_rdata_o[SSPF_RFULL_BIT] <= rx_cnt == CW'(DEPTH);
				io_rdata_o[SSPF_TFULL_BIT] <= tx_cnt == CW'(DEPTH);
			end
		end
	end

	// ==================================================================
	// Interrupt pulses to the processor
	// A transmit request that meets a receive request waits one cycle,
	// so an echo loop can be run entirely from the receive side
	logic receive_interrupt_ev, transmit_interrupt_ev, transmit_interrupt_pend;
	assign receive_interrupt_ev = bf_valid && bf_ready && !rx_pop
		&& rx_cnt == CW'(DEPTH - 1);
	assign transmit_interrupt_ev = word_out && tx_cnt == '0 && !hold_busy;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			receive_interrupt_o <= 1'b0;
			transmit_interrupt_o <= 1'b0;
			transmit_interrupt_pend <= 1'b0;
		end else begin
			receive_interrupt_o <= receive_interrupt_ev && ctrl.rx_run;
			if (receive_interrupt_ev && ctrl.rx_run) begin
				transmit_interrupt_o <= 1'b0;
				transmit_interrupt_pend <= transmit_interrupt_pend || transmit_interrupt_ev;
			end else begin
				transmit_interrupt_o <= transmit_interrupt_ev || transmit_interrupt_pend;
				transmit_interrupt_pend <= 1'b0;
			end
		end
	end

endmodule

// ### verification/sspf_chk.sv
// Assertion checker for the serial port register and link ports
`timescale 1ns/100ps
module sspf_chk import sspf_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [15:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_wdata_i,
	input wire logic [15:0] io_rdata_o,
	input wire logic io_rvalid_o,
	input wire logic transmit_interrupt_o,
	input wire logic receive_interrupt_o,
	input wire logic bit_clk_i,
	input wire logic bit_clk_oe_o,
	input wire logic frame_sync_o,
	input wire logic frame_sync_oe_o
);
	logic [15:0] cfg_q;
	logic mapped;
	assign mapped = io_addr_i == SSPF_DATA_ADDR || io_addr_i == SSPF_CTRL_ADDR;
	// Shadow of the last control write, so readback has a reference
	always_ff @(posedge sys_clk_i) begin
		if (srst_i)
			cfg_q <= SSPF_CTRL_RST;
		else if (io_wr_i && io_addr_i == SSPF_CTRL_ADDR)
			cfg_q <= io_wdata_i;
	end
	// ==========
	// Register port
	a_read_answer:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		io_rd_i && mapped |=> io_rvalid_o)
	else $error("read strobe not answered");
	a_unmapped_quiet:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		io_rvalid_o |-> $past(io_rd_i && mapped))
	else $error("answer without a mapped read");
	a_ctrl_readback:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		$past(io_rd_i && !io_wr_i && io_addr_i == SSPF_CTRL_ADDR) |->
		(io_rdata_o & SSPF_CFG_MASK) == ($past(cfg_q) & SSPF_CFG_MASK))
	else $error("control readback differs from last write");
	// ==========
	// Interrupts are single pulses and never coincide
	a_rx_irq_pulse:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		receive_interrupt_o |=> !receive_interrupt_o)
	else $error("receive interrupt longer than one cycle");
	a_tx_irq_pulse:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		transmit_interrupt_o |=> !transmit_interrupt_o)
	else $error("transmit interrupt longer than one cycle");
	a_irq_order:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		receive_interrupt_o |-> !transmit_interrupt_o)
	else $error("both interrupts in one cycle");
	// ==========
	// Pin drivers stay off for external sources; frame sync lasts one bit clock
	a_clk_src_off:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!cfg_q[SSPF_CLK_INT_BIT] && !$past(cfg_q[SSPF_CLK_INT_BIT])
		|-> !bit_clk_oe_o)
	else $error("bit clock driven while external");
	a_fs_src_off:
	assert property (@(posedge sys_clk_i) disable iff (srst_i)
		!cfg_q[SSPF_FS_INT_BIT] && !$past(cfg_q[SSPF_FS_INT_BIT])
		|-> !frame_sync_oe_o)
	else $error("frame sync driven while external");
	a_fs_one_bit:
	assert property (@(posedge bit_clk_i) disable iff (srst_i)
		frame_sync_o |=> !frame_sync_o)
	else $error("frame sync longer than one bit clock");
endmodule
bind sspf_port sspf_chk chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
	.io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
	.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
	.io_rvalid_o(io_rvalid_o), .transmit_interrupt_o(transmit_interrupt_o),
	.receive_interrupt_o(receive_interrupt_o), .bit_clk_i(bit_clk_i),
	.bit_clk_oe_o(bit_clk_oe_o), .frame_sync_o(frame_sync_o),
	.frame_sync_oe_o(frame_sync_oe_o));

// ### verification/sspf_codec_model.sv
// Behavioural codec model on the far side of the serial link
`timescale 1ns/100ps
module sspf_codec_model (
	input wire logic dev_clk_i,
	input wire logic dev_clk_oe_i,
	input wire logic dev_fs_i,
	input wire logic dev_fs_oe_i,
	input wire logic dev_data_i,
	output logic bit_clk_o,
	output logic fs_o,
	output logic data_o
);
	logic codec_clk;
	logic [15:0] shreg;
	int cnt = 0;
	logic [15:0] cap_q[$];
	// Free-running 6 ns codec clock, phase unrelated to the system clock
	initial begin
		codec_clk = 1'b0;
		#1.3;
		forever #3 codec_clk = ~codec_clk;
	end
	// Whichever side is the selected source drives the line
	assign bit_clk_o = dev_clk_oe_i ? dev_clk_i : codec_clk;
	// Codec never sources syncs here, so it holds its sync output low
	assign fs_o = dev_fs_oe_i ? dev_fs_i : 1'b0;
	// Digital loopback: device output is crossed back to its input
	assign data_o = dev_data_i;
	// Capture framed words at the wire, MSB first
	always @(posedge bit_clk_o) begin
		if (cnt == 0) begin
			if (fs_o === 1'b1)
				cnt = 16;
		end else begin
			shreg = {shreg[14:0], dev_data_i};
			cnt = cnt - 1;
			if (cnt == 0)
				cap_q.push_back(shreg);
		end
	end
endmodule

// ### verification/sync_serial_port_fifo_bench.sv
// Self-checking bench for the serial port with FIFOs
`timescale 1ns/100ps
module sync_serial_port_fifo_bench import sspf_pkg::*;;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [15:0] io_addr_i = 16'h0000;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [15:0] io_wdata_i = 16'h0000;
	logic [15:0] io_rdata_o;
	logic io_rvalid_o, transmit_interrupt_o, receive_interrupt_o;
	logic bit_clk_o, bit_clk_oe_o, frame_sync_o, frame_sync_oe_o;
	logic serial_data_out_o, bit_clk_w, fs_w, sdata_w;
	int failures = 0;
	int checks_done = 0;
	int tx_irqs = 0;
	int rx_irqs = 0;
	logic [31:0] rng = 32'h0000_0017;
	logic [15:0] exp_q[$];
	logic [15:0] sent_q[$];
	always #2 sys_clk_i = ~sys_clk_i;
	sspf_port dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
		.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.io_rvalid_o(io_rvalid_o),
		.transmit_interrupt_o(transmit_interrupt_o),
		.receive_interrupt_o(receive_interrupt_o), .bit_clk_i(bit_clk_w),
		.bit_clk_o(bit_clk_o), .bit_clk_oe_o(bit_clk_oe_o),
		.frame_sync_i(fs_w), .frame_sync_o(frame_sync_o),
		.frame_sync_oe_o(frame_sync_oe_o), .serial_data_in_i(sdata_w),
		.serial_data_out_o(serial_data_out_o));
	sspf_codec_model codec (.dev_clk_i(bit_clk_o),
		.dev_clk_oe_i(bit_clk_oe_o), .dev_fs_i(frame_sync_o),
		.dev_fs_oe_i(frame_sync_oe_o), .dev_data_i(serial_data_out_o),
		.bit_clk_o(bit_clk_w), .fs_o(fs_w), .data_o(sdata_w));
	// Interrupt pulses are counted, the main sequence decides how many are due
	always @(posedge sys_clk_i) begin
		if (transmit_interrupt_o === 1'b1)
			tx_irqs++;
		if (receive_interrupt_o === 1'b1)
			rx_irqs++;
	end
	function automatic logic [15:0] next_rand();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[15:0];
	endfunction
	task automatic check(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========
	// Register access, one strobe cycle each
	task automatic wr(input logic [15:0] a, d);
		@(negedge sys_clk_i);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge sys_clk_i);
		io_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d, v);
		@(negedge sys_clk_i);
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(negedge sys_clk_i);
		io_rd_i = 1'b0;
		v = {15'h0000, io_rvalid_o};
		d = io_rdata_o;
	endtask
	// Sending also records the word for the model and the wire check
	task automatic send(input int n);
		logic [15:0] w;
		for (int i = 0; i < n; i++) begin
			w = next_rand();
			exp_q.push_back(w);
			sent_q.push_back(w);
			wr(SSPF_DATA_ADDR, w);
		end
	endtask
	task automatic wait_cnt(ref int cnt, input int target);
		for (int i = 0; i < 20000 && cnt < target; i++)
			@(negedge sys_clk_i);
		if (cnt < target) begin
			failures++;
			report_and_stop();
		end
	endtask
	task automatic drain(input int n);
		logic [15:0] d, v;
		for (int i = 0; i < n; i++) begin
			rd(SSPF_DATA_ADDR, d, v);
			check("rx word", d, exp_q.pop_front());
		end
	endtask
	// ==========
	// Main sequence
	initial begin
		logic [15:0] d, v;
		int n;
		repeat (10) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		srst_i = 1'b0;
		rd(SSPF_CTRL_ADDR, d, v);
		check("ctrl reset", d, SSPF_CTRL_RST);
		wr(SSPF_CTRL_ADDR, 16'h0002);
		wr(SSPF_CTRL_ADDR, 16'h0032);
		rd(SSPF_CTRL_ADDR, d, v);
		check("ctrl run", d, 16'h0032);
		rd(16'hfff2, d, v);
		check("unmapped answer", v, 16'h0000);
		// Burst, internal sync: four words fill RX with no read
		wr(SSPF_CTRL_ADDR, 16'h0034);
		send(4);
		wait_cnt(tx_irqs, 1);
		check("rx irq early", 16'(rx_irqs), 16'h0000);
		wait_cnt(rx_irqs, 1);
		check("tx irq count", 16'(tx_irqs), 16'h0001);
		rd(SSPF_CTRL_ADDR, d, v);
		check("ctrl full", d, 16'h7034);
		// Two more while RX is full: the buffer must hold them
		send(2);
		for (int i = 0; i < 4000 && codec.cap_q.size() < 6; i++)
			@(negedge sys_clk_i);
		// A missing word on the wire is a hang, not a pass
		if (codec.cap_q.size() < 6) begin
			failures++;
			report_and_stop();
		end
		for (int i = 0; i < 6; i++)
			check("wire word", codec.cap_q[i], sent_q[i]);
		repeat (20) @(negedge sys_clk_i);
		drain(6);
		rd(SSPF_DATA_ADDR, d, v);
		check("empty read", d, 16'h0000);
		rd(SSPF_CTRL_ADDR, d, v);
		check("ctrl drained", d, 16'h2034);
		// Continuous mode: words follow back to back
		wr(SSPF_CTRL_ADDR, 16'h0036);
		send(2);
		wait_cnt(tx_irqs, 3);
		repeat (20) @(negedge sys_clk_i);
		drain(2);
		// Internal bit clock with both halves stopped, so the link
		// clock can change source without upsetting a transfer
		wr(SSPF_CTRL_ADDR, 16'h0301);
		rd(SSPF_CTRL_ADDR, d, v);
		check("ctrl clk", d, 16'h0301);
		check("clk drive", {15'h0000, bit_clk_oe_o}, 16'h0001);
		for (int i = 0; i < 40 && bit_clk_o !== 1'b0; i++)
			@(negedge sys_clk_i);
		for (int i = 0; i < 40 && bit_clk_o !== 1'b1; i++)
			@(negedge sys_clk_i);
		// Divider value 3 gives a high phase of four system clocks
		n = 0;
		for (int i = 0; i < 40 && bit_clk_o === 1'b1; i++) begin
			@(negedge sys_clk_i);
			n++;
		end
		check("clk half period", 16'(n), 16'h0004);
		report_and_stop();
	end
endmodule
